/* File: rtl/vspb_bridge.sv */
`timescale 1ns/10ps
`include "vspb_consts.svh"

module vspb_bridge import vspb_pkg::*; #(
	parameter int RX_DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic targetTxPin,
	output logic targetRxPin,
	output logic ctsOut_b,
	output logic ctsOe,
	input wire logic rtsIn_b,
	input wire logic vcomEnablePin,
	input wire logic sockOpen,
	input wire logic sockInValid,
	input wire logic [7:0] sockInData,
	output logic sockInReady,
	output logic sockOutValid,
	output logic [7:0] sockOutData,
	input wire logic sockOutReady
);

	localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
	localparam int CW = $clog2(RX_DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(RX_DEPTH);

	typedef enum logic {TX_IDLE, TX_SHIFT} vspb_txst_type;

	function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
		nextPtr = (p == PW'(RX_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	function automatic logic [15:0] clampDiv(input logic [15:0] d);
		if (d < 16'(`VSPB_DIV_MIN)) begin
			clampDiv = 16'(`VSPB_DIV_MIN);
		end else if (d > 16'(`VSPB_DIV_MAX)) begin
			clampDiv = 16'(`VSPB_DIV_MAX);
		end else begin
			clampDiv = d;
		end
	endfunction

	vspb_ctrl_type ctrl_q;
	logic rtsMeta_q;
	logic rtsSync_q;
	logic enMeta_q;
	logic enSync_q;
	vspb_byte_type txHold_q;
	vspb_txst_type txState_q;
	logic [9:0] txShift_q;
	logic [3:0] txLeft_q;
	logic [15:0] txCnt_q;
	logic [7:0] rxMem [RX_DEPTH];
	logic [PW-1:0] wrPtr_q;
	logic [PW-1:0] rdPtr_q;
	logic [CW-1:0] rxCount_q;
	logic overrun_q;
	logic frameErr_q;
	logic rxValid;
	logic [7:0] rxData;
	logic rxFrameErr;
	logic pending;
	logic accept;
	logic usbWrite;
	logic usbPop;
	logic sockPush;
	logic sockPop;
	logic rxPush;
	logic txLoad;
	logic txGate;
	logic txFull_d;

	// ==========================================================
	// pin synchronisers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rtsMeta_q <= 1'b1;
			rtsSync_q <= 1'b1;
			enMeta_q <= 1'b0;
			enSync_q <= 1'b0;
		end else begin
			rtsMeta_q <= rtsIn_b;
			rtsSync_q <= rtsMeta_q;
			enMeta_q <= vcomEnablePin;
			enSync_q <= enMeta_q;
		end
	end

	// ==========================================================
	// bus decode
	assign pending = (avs_read || avs_write) && avs_waitrequest;
	// usb side stalls on a full holding byte; the socket side wins a tie
	assign accept = pending && !(avs_write && avs_address == `VSPB_REG_TXDATA && !sockOpen
		&& (txHold_q.valid || sockInReady));
	assign usbWrite = accept && avs_write && avs_address == `VSPB_REG_TXDATA && !sockOpen;
	assign usbPop = accept && avs_read && avs_address == `VSPB_REG_RXDATA && !sockOpen
		&& rxCount_q != '0;
	assign sockPush = sockInValid && sockInReady;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !accept;
			if (accept && avs_read) begin
				avs_readdata <= 32'h0000_0000;
				case (avs_address)
					`VSPB_REG_CTRL: begin
						avs_readdata[`VSPB_CTRL_DIV_LSB +: 16] <= ctrl_q.bitDiv;
						avs_readdata[`VSPB_CTRL_MODE_LSB +: 2] <= ctrl_q.hsMode;
					end
					`VSPB_REG_STATUS: begin
						avs_readdata[`VSPB_ST_TXFULL] <= txHold_q.valid;
						avs_readdata[`VSPB_ST_TXBUSY] <= txState_q == TX_SHIFT;
						avs_readdata[`VSPB_ST_RXAVAIL] <= rxCount_q != '0;
						avs_readdata[`VSPB_ST_RXFULL] <= rxCount_q == FULL_CNT;
						avs_readdata[`VSPB_ST_OVERRUN] <= overrun_q;
						avs_readdata[`VSPB_ST_FRAMEERR] <= frameErr_q;
						avs_readdata[`VSPB_ST_ENABLE] <= enSync_q;
						avs_readdata[`VSPB_ST_SOCKOPEN] <= sockOpen;
						avs_readdata[`VSPB_ST_RTSREADY] <= !rtsSync_q;
						avs_readdata[`VSPB_ST_COUNT_LSB +: CW] <= rxCount_q;
					end
					`VSPB_REG_RXDATA: begin
						avs_readdata[`VSPB_RXD_VALID] <= usbPop;
						avs_readdata[7:0] <= usbPop ? rxMem[rdPtr_q] : 8'h00;
					end
					default: begin
						avs_readdata <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// control register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q.bitDiv <= 16'(`VSPB_DIV_DEF);
			ctrl_q.hsMode <= VSPB_HS_DISABLED;
		end else if (accept && avs_write && avs_address == `VSPB_REG_CTRL) begin
			ctrl_q.bitDiv <= clampDiv(avs_writedata[`VSPB_CTRL_DIV_LSB +: 16]);
			ctrl_q.hsMode <= vspb_hs_type'(avs_writedata[`VSPB_CTRL_MODE_LSB +: 2]);
		end
	end

	// ==========================================================
	// sticky error flags, set beats clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			overrun_q <= 1'b0;
			frameErr_q <= 1'b0;
		end else begin
			if (rxValid && rxCount_q == FULL_CNT && !sockPop && !usbPop) begin
				overrun_q <= 1'b1;
			end else if (accept && avs_write && avs_address == `VSPB_REG_STATUS
				&& avs_writedata[`VSPB_ST_OVERRUN]) begin
				overrun_q <= 1'b0;
			end
			if (rxFrameErr) begin
				frameErr_q <= 1'b1;
			end else if (accept && avs_write && avs_address == `VSPB_REG_STATUS
				&& avs_writedata[`VSPB_ST_FRAMEERR]) begin
				frameErr_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// holding byte toward the target
	assign txGate = (ctrl_q.hsMode == VSPB_HS_CTS || ctrl_q.hsMode == VSPB_HS_RTSCTS)
		&& rtsSync_q;
	assign txLoad = txState_q == TX_IDLE && txHold_q.valid && enSync_q && !txGate;
	assign txFull_d = (txHold_q.valid && !txLoad) || usbWrite || sockPush;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txHold_q <= '0;
			sockInReady <= 1'b0;
		end else begin
			if (usbWrite) begin
				txHold_q.data <= avs_writedata[7:0];
			end else if (sockPush) begin
				txHold_q.data <= sockInData;
			end
			txHold_q.valid <= txFull_d;
			sockInReady <= sockOpen && !txFull_d;
		end
	end

	// ==========================================================
	// transmitter; rts falling mid-frame never cuts the frame
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			txState_q <= TX_IDLE;
			txShift_q <= 10'h3FF;
			txLeft_q <= 4'h0;
			txCnt_q <= 16'h0000;
			targetRxPin <= 1'b1;
		end else begin
			case (txState_q)
				TX_IDLE: begin
					targetRxPin <= 1'b1;
					if (txLoad) begin
						targetRxPin <= 1'b0;
						txShift_q <= {1'b1, 1'b1, txHold_q.data};
						txLeft_q <= `VSPB_FRAME_UPDATES;
						txCnt_q <= ctrl_q.bitDiv - 1'b1;
						txState_q <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (txCnt_q != 16'h0000) begin
						txCnt_q <= txCnt_q - 1'b1;
					end else if (txLeft_q == 4'h0) begin
						txState_q <= TX_IDLE;
					end else begin
						targetRxPin <= txShift_q[0];
						txShift_q <= {1'b1, txShift_q[9:1]};
						txLeft_q <= txLeft_q - 4'h1;
						txCnt_q <= ctrl_q.bitDiv - 1'b1;
					end
				end
				default: begin
					txState_q <= TX_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// receive buffer from the target
	vspb_uart_rx #(
		.DIV_W(16)
	) uRx (
		.clk(clk),
		.rst_b(rst_b),
		.enable(enSync_q),
		.bitDiv(ctrl_q.bitDiv),
		.rxdPin(targetTxPin),
		.rxValid(rxValid),
		.rxData(rxData),
		.frameErr(rxFrameErr)
	);

	assign sockPop = sockOpen && rxCount_q != '0 && (!sockOutValid || sockOutReady);
	assign rxPush = rxValid && (rxCount_q != FULL_CNT || sockPop || usbPop);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			rxCount_q <= '0;
		end else begin
			if (rxPush) begin
				wrPtr_q <= nextPtr(wrPtr_q);
			end
			if (sockPop || usbPop) begin
				rdPtr_q <= nextPtr(rdPtr_q);
			end
			if (rxPush && !(sockPop || usbPop)) begin
				rxCount_q <= rxCount_q + 1'b1;
			end else if (!rxPush && (sockPop || usbPop)) begin
				rxCount_q <= rxCount_q - 1'b1;
			end
		end
	end

	// storage needs no reset; reads are guarded by the count
	always_ff @(posedge clk) begin
		if (rxPush) begin
			rxMem[wrPtr_q] <= rxData;
		end
	end

	// ==========================================================
	// socket output stage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sockOutValid <= 1'b0;
			sockOutData <= 8'h00;
		end else if (sockPop) begin
			sockOutValid <= 1'b1;
			sockOutData <= rxMem[rdPtr_q];
		end else if (sockOutReady) begin
			sockOutValid <= 1'b0;
		end
	end

	// ==========================================================
	// clear-to-send toward the target, active low
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctsOut_b <= 1'b0;
			ctsOe <= 1'b0;
		end else begin
			// one cycle late; the last slot absorbs nothing, so overrun is flagged
			ctsOut_b <= rxCount_q == FULL_CNT;
			ctsOe <= ctrl_q.hsMode == VSPB_HS_RTS
				|| ctrl_q.hsMode == VSPB_HS_RTSCTS;
		end
	end

endmodule

/* File: rtl/vspb_consts.svh */
`ifndef VSPB_CONSTS_SVH
`define VSPB_CONSTS_SVH

// ==========================================================
// clock and baud figures
`define VSPB_CLK_HZ 20000000
`define VSPB_BAUD_DEF 115200
`define VSPB_BAUD_MIN 9600
`define VSPB_BAUD_MAX 921600
`define VSPB_DIV_DEF ((`VSPB_CLK_HZ + (`VSPB_BAUD_DEF / 2)) / `VSPB_BAUD_DEF)
`define VSPB_DIV_MAX ((`VSPB_CLK_HZ + (`VSPB_BAUD_MIN / 2)) / `VSPB_BAUD_MIN)
`define VSPB_DIV_MIN ((`VSPB_CLK_HZ + (`VSPB_BAUD_MAX / 2)) / `VSPB_BAUD_MAX)

// ==========================================================
// register word offsets
`define VSPB_REG_CTRL 3'h0
`define VSPB_REG_STATUS 3'h1
`define VSPB_REG_TXDATA 3'h2
`define VSPB_REG_RXDATA 3'h3

// ==========================================================
// field positions
`define VSPB_CTRL_DIV_LSB 0
`define VSPB_CTRL_MODE_LSB 16
`define VSPB_ST_TXFULL 0
`define VSPB_ST_TXBUSY 1
`define VSPB_ST_RXAVAIL 2
`define VSPB_ST_RXFULL 3
`define VSPB_ST_OVERRUN 4
`define VSPB_ST_FRAMEERR 5
`define VSPB_ST_ENABLE 6
`define VSPB_ST_SOCKOPEN 7
`define VSPB_ST_RTSREADY 8
`define VSPB_ST_COUNT_LSB 12
`define VSPB_RXD_VALID 8

// ==========================================================
// frame shape: 8N1
`define VSPB_DATA_BITS 8
`define VSPB_FRAME_UPDATES 4'h9

`endif

/* File: rtl/vspb_pkg.sv */
package vspb_pkg;

	// ==========================================================
	// handshake modes, in register encoding order
	typedef enum logic [1:0] {
		VSPB_HS_DISABLED,
		VSPB_HS_RTS,
		VSPB_HS_CTS,
		VSPB_HS_RTSCTS
	} vspb_hs_type;

	typedef struct packed {
		vspb_hs_type hsMode;
		logic [15:0] bitDiv;
	} vspb_ctrl_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} vspb_byte_type;

endpackage

/* File: rtl/vspb_uart_rx.sv */
`timescale 1ns/10ps
`include "vspb_consts.svh"

module vspb_uart_rx import vspb_pkg::*; #(
	parameter int DIV_W = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic [DIV_W-1:0] bitDiv,
	input wire logic rxdPin,
	output logic rxValid,
	output logic [7:0] rxData,
	output logic frameErr
);

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} vspb_rxst_type;

	vspb_rxst_type state_q;
	logic rxdMeta_q;
	logic rxdSync_q;
	logic [DIV_W-1:0] cnt_q;
	logic [2:0] bitIdx_q;
	logic [7:0] shift_q;

	// ==========================================================
	// pin synchroniser, idles high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rxdMeta_q <= 1'b1;
			rxdSync_q <= 1'b1;
		end else begin
			rxdMeta_q <= rxdPin;
			rxdSync_q <= rxdMeta_q;
		end
	end

	// ==========================================================
	// frame receiver, samples mid-bit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= RX_IDLE;
			cnt_q <= '0;
			bitIdx_q <= 3'h0;
			shift_q <= 8'h00;
			rxValid <= 1'b0;
			rxData <= 8'h00;
			frameErr <= 1'b0;
		end else begin
			rxValid <= 1'b0;
			frameErr <= 1'b0;
			if (!enable) begin
				state_q <= RX_IDLE;
			end else begin
				case (state_q)
					RX_IDLE: begin
						if (!rxdSync_q) begin
							cnt_q <= bitDiv >> 1;
							state_q <= RX_START;
						end
					end
					RX_START: begin
						if (cnt_q == '0) begin
							// glitch shorter than half a bit is dropped
							state_q <= rxdSync_q ? RX_IDLE : RX_DATA;
							cnt_q <= bitDiv - 1'b1;
							bitIdx_q <= 3'h0;
						end else begin
							cnt_q <= cnt_q - 1'b1;
						end
					end
					RX_DATA: begin
						if (cnt_q == '0) begin
							shift_q <= {rxdSync_q, shift_q[7:1]};
							cnt_q <= bitDiv - 1'b1;
							bitIdx_q <= bitIdx_q + 3'h1;
							if (bitIdx_q == 3'h7) begin
								state_q <= RX_STOP;
							end
						end else begin
							cnt_q <= cnt_q - 1'b1;
						end
					end
					RX_STOP: begin
						if (cnt_q == '0) begin
							rxValid <= rxdSync_q;
							frameErr <= !rxdSync_q;
							rxData <= shift_q;
							state_q <= RX_IDLE;
						end else begin
							cnt_q <= cnt_q - 1'b1;
						end
					end
					default: begin
						state_q <= RX_IDLE;
					end
				endcase
			end
		end
	end

endmodule

/* File: verification/vspb_bridge_props.sv */
`timescale 1ns/10ps
module vspb_bridge_props import vspb_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic targetTxPin,
	input wire logic targetRxPin,
	input wire logic ctsOut_b,
	input wire logic ctsOe,
	input wire logic rtsIn_b,
	input wire logic sockOpen,
	input wire logic sockOutValid,
	input wire logic [7:0] sockOutData,
	input wire logic sockOutReady
);
	// ==========
	// shadow of the control word, seen from the bus
	logic ctrlWr;
	logic [1:0] modeQ;
	logic [15:0] divQ;
	logic [15:0] rtsHiQ;
	assign ctrlWr = avs_write && avs_waitrequest && avs_address == 3'h0;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			modeQ <= 2'h0;
			divQ <= 16'h00AE;
		end else if (ctrlWr) begin
			modeQ <= avs_writedata[17:16];
			divQ <= avs_writedata[15:0] < 16'h0016 ? 16'h0016 :
				avs_writedata[15:0] > 16'h0823 ? 16'h0823 : avs_writedata[15:0];
		end
	end
	// counts how long the gate has been closed; saturates
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rtsHiQ <= 16'h0000;
		end else if (!(modeQ[1] && rtsIn_b)) begin
			rtsHiQ <= 16'h0000;
		end else if (rtsHiQ != 16'hFFFF) begin
			rtsHiQ <= rtsHiQ + 16'h0001;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ==========
	// checks
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("read not answered in one cycle");
	a_cts_drive: assert property (!$past(ctrlWr) |-> ctsOe == modeQ[0])
		else $error("clear-to-send enable does not follow the mode");
	a_cts_full: assert property ($rose(ctsOut_b) |-> $past(targetTxPin, 6))
		else $error("clear-to-send dropped away from a stop bit");
	a_start_len: assert property ($fell(targetRxPin) |-> (!targetRxPin)[*8])
		else $error("low bit on the serial output too short");
	a_rts_gates_tx: assert property (
		modeQ[1] && 32'(rtsIn_b ? rtsHiQ : 16'h0000) > 32'(divQ) * 12 |-> targetRxPin)
		else $error("sending while request-to-send is deasserted");
	a_sock_usb_zero: assert property (
		sockOpen && avs_read && avs_waitrequest && avs_address == 3'h3 |=> avs_readdata == 32'h0)
		else $error("usb read delivered data while the socket is open");
	a_sock_out_open: assert property ($rose(sockOutValid) |-> $past(sockOpen))
		else $error("socket output started without a socket");
	a_out_held: assert property (
		sockOutValid && !sockOutReady |=> sockOutValid && $stable(sockOutData))
		else $error("socket output byte not held");
endmodule

bind vspb_bridge vspb_bridge_props i_props (
	.clk(clk),
	.rst_b(rst_b),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.targetTxPin(targetTxPin),
	.targetRxPin(targetRxPin),
	.ctsOut_b(ctsOut_b),
	.ctsOe(ctsOe),
	.rtsIn_b(rtsIn_b),
	.sockOpen(sockOpen),
	.sockOutValid(sockOutValid),
	.sockOutData(sockOutData),
	.sockOutReady(sockOutReady)
);

/* File: verification/vspb_bridge_tb.sv */
`timescale 1ns/10ps
module vspb_bridge_tb import vspb_pkg::*;;
	typedef struct packed {logic [31:0] wd; logic [31:0] ex;} vspb_row_type;
	vspb_row_type rows [4] = '{'{32'h00000005, 32'h00000016}, '{32'h0001FFFF, 32'h00010823},
		'{32'h00020823, 32'h00020823}, '{32'h00030016, 32'h00030016}};
	logic clk, rst_b, avs_read, avs_write, avs_waitrequest, targetTxPin, targetRxPin;
	logic ctsOut_b, ctsOe, ctsLine, rtsIn_b, vcomEnablePin, sockOpen, holdOff;
	logic sockInValid, sockInReady, sockOutValid, sockOutReady;
	logic [2:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [7:0] sockInData, sockOutData;
	int fails, comparisons;
	// undriven line has a pull-down, so the target is never held by accident
	assign ctsLine = ctsOe ? ctsOut_b : 1'b0;
	vspb_bridge #(.RX_DEPTH(4)) i_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.targetTxPin(targetTxPin), .targetRxPin(targetRxPin), .ctsOut_b(ctsOut_b),
		.ctsOe(ctsOe), .rtsIn_b(rtsIn_b), .vcomEnablePin(vcomEnablePin), .sockOpen(sockOpen),
		.sockInValid(sockInValid), .sockInData(sockInData), .sockInReady(sockInReady),
		.sockOutValid(sockOutValid), .sockOutData(sockOutData), .sockOutReady(sockOutReady));
	vspb_target_model i_target (.clk(clk), .bitDiv(16'h0016), .rxLine(targetRxPin),
		.ctsIn_b(ctsLine), .holdOff(holdOff), .txLine(targetTxPin), .rtsOut_b(rtsIn_b));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task chk(input string what, input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, ex, got);
		end
	endtask
	task bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task endTest(input string name);
		$display("test %s finished", name);
	endtask
	task print_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// a full run is well under 10000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		print_verdict;
	end
	initial begin
		{rst_b, avs_read, avs_write, sockOpen, sockInValid, sockOutReady, holdOff} = 7'h00;
		{avs_address, avs_writedata, sockInData} = 43'h0;
		vcomEnablePin = 1'b1;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		bus(1'b0, 3'h0, 32'h0);
		chk("ctrl", 32'h000000AE, rd);
		chk("ctsOe", 32'h0, {31'h0, ctsOe});
		endTest("reset");
		foreach (rows[i]) begin
			bus(1'b1, 3'h0, rows[i].wd);
			bus(1'b0, 3'h0, 32'h0);
			chk("ctrl", rows[i].ex, rd);
		end
		bus(1'b1, 3'h5, 32'hFFFFFFFF);
		bus(1'b0, 3'h5, 32'h0);
		chk("unmapped", 32'h0, rd);
		endTest("config");
		bus(1'b1, 3'h2, 32'h00000081);
		repeat (60) @(posedge clk);
		holdOff <= 1'b1;
		bus(1'b1, 3'h2, 32'h0000005A);
		repeat (400) @(posedge clk);
		chk("tx count", 32'h1, 32'(i_target.rxQ.size()));
		chk("tx byte", 32'h81, {24'h0, i_target.rxQ.pop_front()});
		holdOff <= 1'b0;
		repeat (400) @(posedge clk);
		chk("tx byte", 32'h5A, {24'h0, i_target.rxQ.pop_front()});
		bus(1'b1, 3'h0, 32'h00000016);
		holdOff <= 1'b1;
		bus(1'b1, 3'h2, 32'h000000C3);
		repeat (400) @(posedge clk);
		chk("tx byte", 32'hC3, {24'h0, i_target.rxQ.pop_front()});
		// cts mode: gated by the target, clear-to-send left undriven
		bus(1'b1, 3'h0, 32'h00020016);
		bus(1'b1, 3'h2, 32'h000000E1);
		repeat (300) @(posedge clk);
		chk("tx count", 32'h0, 32'(i_target.rxQ.size()));
		chk("ctsOe", 32'h0, {31'h0, ctsOe});
		holdOff <= 1'b0;
		repeat (300) @(posedge clk);
		chk("tx byte", 32'hE1, {24'h0, i_target.rxQ.pop_front()});
		endTest("tx gating");
		bus(1'b1, 3'h0, 32'h00010016);
		for (int i = 0; i < 4; i++) i_target.send(8'hA5 ^ 8'(i));
		repeat (10) @(posedge clk);
		chk("cts", 32'h1, {31'h0, ctsOut_b});
		chk("ctsOe", 32'h1, {31'h0, ctsOe});
		bus(1'b0, 3'h1, 32'h0);
		chk("status", 32'h0000414C, rd);
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 3'h3, 32'h0);
			chk("rx byte", {23'h0, 1'b1, 8'hA5 ^ 8'(i)}, rd);
		end
		chk("cts", 32'h0, {31'h0, ctsOut_b});
		endTest("rx flow");
		vcomEnablePin <= 1'b0;
		repeat (4) @(posedge clk);
		i_target.send(8'h3C);
		bus(1'b0, 3'h3, 32'h0);
		chk("rx valid", 32'h0, {31'h0, rd[8]});
		bus(1'b1, 3'h2, 32'h00000096);
		repeat (300) @(posedge clk);
		chk("tx count", 32'h0, 32'(i_target.rxQ.size()));
		vcomEnablePin <= 1'b1;
		repeat (300) @(posedge clk);
		chk("tx byte", 32'h96, {24'h0, i_target.rxQ.pop_front()});
		endTest("enable");
		sockOpen <= 1'b1;
		i_target.send(8'h4B);
		i_target.send(8'h5C);
		repeat (5) @(posedge clk);
		chk("sock out", 32'h14B, {23'h0, sockOutValid, sockOutData});
		bus(1'b0, 3'h3, 32'h0);
		chk("usb rx", 32'h0, rd);
		sockOutReady <= 1'b1;
		@(posedge clk);
		sockOutReady <= 1'b0;
		repeat (3) @(posedge clk);
		chk("sock out", 32'h15C, {23'h0, sockOutValid, sockOutData});
		bus(1'b1, 3'h2, 32'h00000077);
		// rts mode must not gate on the target's hold-off
		holdOff <= 1'b1;
		sockInValid <= 1'b1;
		sockInData <= 8'h69;
		do @(posedge clk); while (sockInReady !== 1'b1);
		sockInValid <= 1'b0;
		repeat (300) @(posedge clk);
		chk("tx count", 32'h1, 32'(i_target.rxQ.size()));
		chk("sock in", 32'h69, {24'h0, i_target.rxQ.pop_front()});
		holdOff <= 1'b0;
		endTest("socket");
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		chk("reset bus pin", 32'h3, {30'h0, avs_waitrequest, targetRxPin});
		chk("reset cts sock", 32'h0, {30'h0, ctsOe, sockOutValid});
		rst_b <= 1'b1;
		bus(1'b0, 3'h0, 32'h0);
		chk("ctrl", 32'h000000AE, rd);
		endTest("mid reset");
		print_verdict;
	end
endmodule

/* File: verification/vspb_target_model.sv */
`timescale 1ns/10ps
module vspb_target_model (
	input wire logic clk,
	input wire logic [15:0] bitDiv,
	input wire logic rxLine,
	input wire logic ctsIn_b,
	input wire logic holdOff,
	output logic txLine,
	output logic rtsOut_b
);
	logic [7:0] rxQ[$];
	assign rtsOut_b = holdOff;
	initial txLine = 1'b1;
	task automatic send(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		@(posedge clk);
		while (ctsIn_b !== 1'b0) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			txLine <= fr[i];
			repeat (bitDiv) @(posedge clk);
		end
	endtask
	// keeps receiving whatever holdOff says: one more byte may follow
	initial forever begin
		logic [7:0] d;
		@(negedge rxLine);
		repeat (bitDiv / 2) @(posedge clk);
		if (rxLine === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (bitDiv) @(posedge clk);
				d[i] = rxLine;
			end
			repeat (bitDiv) @(posedge clk);
			if (rxLine === 1'b1) rxQ.push_back(d);
		end
	end
endmodule
